// ===== verilog/serial_unit_pkg.sv
/*
  Constants and types shared by the synchronous serial unit.
  Assumes a single clock domain and synchronous active-high reset.
*/
`default_nettype none

package serial_unit_pkg;

  // ---------------------------------------------------------------
  // Widths and telegram lengths
  // ---------------------------------------------------------------
  localparam int         DATA_W     = 8;
  localparam int         CNT_W      = 4;
  localparam logic [3:0] BITS_PLAIN = 4'h8;
  localparam logic [3:0] BITS_ACK   = 4'h9;
  localparam logic [3:0] ACK_POS    = 4'h8;

  // ---------------------------------------------------------------
  // Serial mode field {bit1, bit0}
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_NRZ_RISE = 2'h3;
  localparam logic [1:0] MODE_NRZ_FALL = 2'h2;
  localparam logic [1:0] MODE_MCL9     = 2'h1;
  localparam logic [1:0] MODE_MCL8     = 2'h0;

  // ---------------------------------------------------------------
  // Internal clock source select
  // ---------------------------------------------------------------
  localparam logic [1:0] CLKSEL_SYS  = 2'h3;
  localparam logic [1:0] CLKSEL_T1   = 2'h2;
  localparam logic [1:0] CLKSEL_POUT = 2'h1;
  localparam logic [1:0] CLKSEL_TOG2 = 2'h0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic              RST_RDY  = 1'h0;
  localparam logic              RST_LINE = 1'h1;
  localparam logic [DATA_W-1:0] RST_BUF  = 8'h00;

  typedef enum logic [2:0] {
    st_off, st_start, st_idle, st_shift, st_hold, st_stop, st_stop_rel
  } state_e;

endpackage

`default_nettype wire

// ===== verilog/shift_clk_if.sv
/*
  Shift clock link between the clock generator and the control.
  Assumes both ends sit on the same system clock.
*/
`default_nettype none

interface shift_clk_if;
  logic run;
  logic tick;
  logic sc;

  modport gen  (input run, output tick, output sc);
  modport user (output run, input tick, input sc);
endinterface

`default_nettype wire

// ===== verilog/shift_register.sv
/*
  Parallel-load shift register, MSB out first, LSB filled from input.
  Assumes load and shift are never asserted together.
*/
`default_nettype none

module shift_register #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             shift,
  input  wire logic             in_bit,
  output logic      [WIDTH-1:0] q
);

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (load) begin
      q <= load_val;
    end else if (shift) begin
      q <= {q[WIDTH-2:0], in_bit};
    end
  end

endmodule

`default_nettype wire

// ===== verilog/shift_clock_gen.sv
/*
  Shift clock generator: internal source halved, or external pin edges.
  Assumes source enables are one-cycle pulses and the pin is synchronous.
*/
`default_nettype none

module shift_clock_gen
  import serial_unit_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ext_clk,
  input  wire logic       combined_mode,
  input  wire logic [1:0] source_sel,
  input  wire logic       t1out_en,
  input  wire logic       pout_en,
  input  wire logic       tog2_en,
  input  wire logic       timer_clk_en,
  input  wire logic       sc_pin,
  shift_clk_if.gen        sck
);

  logic pin_q;
  logic sc_int;
  logic src_en;

  // ---------------------------------------------------------------
  // Source select
  // ---------------------------------------------------------------
  always_comb begin
    case (source_sel)
      CLKSEL_SYS:  src_en = 1'h1;
      CLKSEL_T1:   src_en = t1out_en;
      CLKSEL_POUT: src_en = pout_en;
      CLKSEL_TOG2: src_en = tog2_en;
      default:     src_en = 1'h0;
    endcase
    if (combined_mode) begin
      src_en = timer_clk_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q <= RST_LINE;
    end else begin
      pin_q <= sc_pin;
    end
  end

  // Toggle per source pulse halves the source rate
  always_ff @(posedge clk) begin
    if (rst) begin
      sc_int <= RST_LINE;
    end else if (!ext_clk && src_en && sck.run) begin
      sc_int <= ~sc_int;
    end
  end

  assign sck.tick = ext_clk ? (sc_pin != pin_q) : src_en;
  assign sck.sc   = ext_clk ? pin_q : sc_int;

endmodule

`default_nettype wire

// ===== verilog/sync_serial_unit.sv
/*
  Synchronous serial unit: 8-bit shift register with receive and
  transmit buffers, NRZ and two-wire master protocol modes.
  Assumes software strobes are one-cycle pulses and pins are synchronous.
*/
// How it works
// - One 8-bit shift register plus software-visible receive and transmit buffers.
// - Telegrams are 8 bits, most significant bit first.
// - The 9-bit master-protocol mode adds one acknowledge bit per telegram.
// - Modes: 8-bit NRZ, 9-bit master protocol, 8-bit pseudo protocol.
// - Telegram start copies transmit buffer to shifter and shifts out at once.
// - Completed telegram moves into the receive buffer automatically.
// - Interface reset bit low activates; high deactivates.
// - Ready flag shows transmit or receive buffer state per direction.
// - Shifting pauses while not ready; buffer write or read resumes it.
// - Busy stays high during telegrams and start or stop conditions.
// - Shift clock internal from selected source or external; direction bit chooses.
// - Combined timer mode takes the timer's clock instead.
// - Master-protocol modes always drive the shift clock.
// - Data pin direction follows the data direction bit.
// - Two-wire: one bidirectional data line and one clock line.
// - Three-wire: data in on its own pin, data out to the timer stage.
// - NRZ data changes on the chosen edge, sampled on the opposite one.
// - Receive: activation clocks 8 bits, buffers them, updates ready, interrupts.
// - Receive: unread buffer makes the unit hold the next telegram.
// - Deactivating mid-telegram in NRZ modes stops the clock and latches the partial word.
// - Mode codes: 11 rise, 10 fall, 01 9-bit protocol, 00 pseudo.
// - Direction bit 1 transmits with pin out, 0 receives with pin in.
`default_nettype none

module sync_serial_unit
  import serial_unit_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              interface_reset_bit,
  input  wire logic                              clock_direction_bit,
  input  wire logic [1:0]                        clock_source_sel,
  input  wire logic                              serial_mode_bit1,
  input  wire logic                              serial_mode_bit0,
  input  wire logic                              data_direction_bit,
  input  wire logic                              three_wire,
  input  wire logic                              combined_mode,
  input  wire logic                              int_enable,
  input  wire logic                              rx_ack_value,
  input  wire logic                              t1out_en,
  input  wire logic                              pout_en,
  input  wire logic                              tog2_en,
  input  wire logic                              timer_clk_en,
  input  wire logic                              tx_write,
  input  wire logic [serial_unit_pkg::DATA_W-1:0] tx_wdata,
  input  wire logic                              rx_read,
  output logic      [serial_unit_pkg::DATA_W-1:0] receive_buffer,
  output logic      [serial_unit_pkg::DATA_W-1:0] transmit_buffer,
  output logic                                   buffer_ready_flag,
  output logic                                   busy_indicator,
  output logic                                   tx_ack,
  output logic                                   irq,
  input  wire logic                              shift_clock_line_i,
  output logic                                   shift_clock_line_o,
  output logic                                   shift_clock_line_oe,
  input  wire logic                              serial_data_line_i,
  output logic                                   serial_data_line_o,
  output logic                                   serial_data_line_oe,
  output logic                                   timer2_so
);

  import serial_unit_pkg::*;

  shift_clk_if sck ();

  state_e              state;
  logic [1:0]          mode;
  logic                nrz;
  logic                mcl9;
  logic                ext_clk;
  logic                rise;
  logic                fall;
  logic                launch;
  logic                capture;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    nbits;
  logic                ack_phase;
  logic                done;
  logic                can_start;
  logic                load_now;
  logic                xfer_now;
  logic                partial;
  logic                shift_now;
  logic                out_bit;
  logic                sdd_q;
  logic                sdd_chg;
  logic [DATA_W-1:0]   sr_q;

  // ---------------------------------------------------------------
  // Mode decode and edge roles
  // ---------------------------------------------------------------
  assign mode    = {serial_mode_bit1, serial_mode_bit0};
  assign nrz     = mode[1];
  assign mcl9    = (mode == MODE_MCL9);
  assign nbits   = mcl9 ? BITS_ACK : BITS_PLAIN;
  assign ext_clk = ~clock_direction_bit & nrz;
  assign rise    = sck.tick & ~sck.sc;
  assign fall    = sck.tick & sck.sc;
  // Rising launch only in mode 11; protocol modes change in low phase
  assign launch  = (mode == MODE_NRZ_RISE) ? rise : fall;
  assign capture = (mode == MODE_NRZ_RISE) ? fall : rise;
  assign ack_phase = mcl9 && (cnt == ACK_POS);

  // Telegram ends with the clock back at its high rest level
  assign done = (state == st_shift) && (cnt == nbits) && sck.sc;
  assign sck.run = ((state == st_shift) && !done) || (state == st_stop);

  // Transmit needs a loaded buffer; receive starts and holds at the end
  assign can_start = data_direction_bit ? buffer_ready_flag : 1'h1;
  assign load_now  = (state == st_idle) && !interface_reset_bit &&
                     can_start;
  assign partial   = (state == st_shift) && nrz && interface_reset_bit;
  assign xfer_now  = (done && (data_direction_bit || buffer_ready_flag)) ||
                     ((state == st_hold) && buffer_ready_flag);
  assign shift_now = (state == st_shift) && capture && !ack_phase &&
                     (cnt < nbits);

  // ---------------------------------------------------------------
  // Clock generator and shift register
  // ---------------------------------------------------------------
  shift_clock_gen shift_clock_gen_inst (
    .clk           (clk),
    .rst           (rst),
    .ext_clk       (ext_clk),
    .combined_mode (combined_mode),
    .source_sel    (clock_source_sel),
    .t1out_en      (t1out_en),
    .pout_en       (pout_en),
    .tog2_en       (tog2_en),
    .timer_clk_en  (timer_clk_en),
    .sc_pin        (shift_clock_line_i),
    .sck           (sck.gen)
  );

  shift_register #(.WIDTH(DATA_W)) shift_register_inst (
    .clk      (clk),
    .rst      (rst),
    .load     (load_now),
    .load_val (transmit_buffer),
    .shift    (shift_now),
    .in_bit   (serial_data_line_i),
    .q        (sr_q)
  );

  // ---------------------------------------------------------------
  // Control sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= st_off;
    end else begin
      case (state)
        st_off: begin
          if (!interface_reset_bit) begin
            state <= nrz ? st_idle : st_start;
          end
        end
        st_start: begin
          if (sck.tick) begin
            state <= st_idle;
          end
        end
        st_idle: begin
          if (interface_reset_bit) begin
            state <= nrz ? st_off : st_stop;
          end else if (can_start) begin
            state <= st_shift;
          end
        end
        st_shift: begin
          if (partial) begin
            state <= st_off;
          end else if (done) begin
            state <= xfer_now ? st_idle : st_hold;
          end
        end
        st_hold: begin
          if (buffer_ready_flag) begin
            state <= st_idle;
          end else if (interface_reset_bit && nrz) begin
            state <= st_off;
          end
        end
        st_stop: begin
          if (rise) begin
            state <= st_stop_rel;
          end
        end
        st_stop_rel: begin
          if (sck.tick) begin
            state <= st_off;
          end
        end
        default: state <= st_off;
      endcase
    end
  end

  // Bit counter
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else if (load_now) begin
      cnt <= '0;
    end else if ((state == st_shift) && capture && (cnt < nbits)) begin
      cnt <= cnt + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Data line level, start and stop conditions
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      out_bit <= RST_LINE;
    end else if ((state == st_off) && !interface_reset_bit && !nrz) begin
      out_bit <= 1'h0; // start: data falls with clock high
    end else if (load_now && nrz) begin
      out_bit <= transmit_buffer[DATA_W-1];
    end else if ((state == st_shift) && launch) begin
      out_bit <= ack_phase ? rx_ack_value : sr_q[DATA_W-1];
    end else if ((state == st_stop) && fall) begin
      out_bit <= 1'h0;
    end else if ((state == st_stop_rel) && sck.tick) begin
      out_bit <= 1'h1; // stop: data rises with clock high
    end else if (state == st_off) begin
      out_bit <= RST_LINE;
    end
  end

  // Acknowledge received while transmitting
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_ack <= 1'h0;
    end else if ((state == st_shift) && capture && ack_phase &&
                 data_direction_bit) begin
      tx_ack <= serial_data_line_i;
    end
  end

  // ---------------------------------------------------------------
  // Buffers and ready flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_buffer <= RST_BUF;
    end else if (tx_write) begin
      transmit_buffer <= tx_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      receive_buffer <= RST_BUF;
    end else if (xfer_now || partial) begin
      receive_buffer <= sr_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sdd_q <= 1'h1;
    end else begin
      sdd_q <= data_direction_bit;
    end
  end

  assign sdd_chg = (sdd_q != data_direction_bit);

  // Software set wins over hardware clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      buffer_ready_flag <= RST_RDY;
    end else if (sdd_chg) begin
      buffer_ready_flag <= ~data_direction_bit;
    end else if (data_direction_bit ? tx_write : rx_read) begin
      buffer_ready_flag <= 1'h1;
    end else if (data_direction_bit ? load_now : xfer_now) begin
      buffer_ready_flag <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= int_enable && xfer_now;
    end
  end

  // ---------------------------------------------------------------
  // Status and pins
  // ---------------------------------------------------------------
  always_comb begin
    case (state)
      st_start, st_shift, st_stop, st_stop_rel: busy_indicator = 1'h1;
      default:                                  busy_indicator = 1'h0;
    endcase
  end

  assign shift_clock_line_o  = sck.sc;
  assign shift_clock_line_oe = ~ext_clk;
  assign serial_data_line_o  = out_bit;
  assign timer2_so           = out_bit;

  always_comb begin
    case (state)
      st_off:   serial_data_line_oe = 1'h0;
      st_shift: serial_data_line_oe = data_direction_bit ^ ack_phase;
      st_start, st_stop, st_stop_rel: serial_data_line_oe = 1'h1;
      default:  serial_data_line_oe = data_direction_bit;
    endcase
    if (three_wire) begin
      serial_data_line_oe = 1'h0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  load_copy_a: assert property (
    load_now |=> (sr_q == $past(transmit_buffer)) && state == st_shift)
    else $error("shift register not loaded from transmit buffer");

  xfer_copy_a: assert property (
    xfer_now |=> receive_buffer == $past(sr_q))
    else $error("receive buffer missed completed telegram");

  off_hold_a: assert property (
    (state == st_off && interface_reset_bit) |=> state == st_off)
    else $error("unit left reset while deactivated");

  tx_pause_a: assert property (
    (state == st_idle && data_direction_bit && !buffer_ready_flag)
    |=> state != st_shift)
    else $error("transmit started with empty buffer");

  busy_shift_a: assert property (
    (state == st_shift || state == st_stop) |-> busy_indicator)
    else $error("busy low during activity");

  mcl_master_a: assert property (
    !nrz |-> shift_clock_line_oe)
    else $error("protocol mode not driving shift clock");

  dir_pin_a: assert property (
    (state == st_shift && !ack_phase && !three_wire)
    |-> serial_data_line_oe == data_direction_bit)
    else $error("data pin direction wrong");

  hold_keep_a: assert property (
    (state == st_hold && !buffer_ready_flag)
    |=> $stable(receive_buffer))
    else $error("unread receive buffer overwritten");

  partial_latch_a: assert property (
    partial |=> state == st_off && receive_buffer == $past(sr_q) &&
                !sck.run)
    else $error("partial telegram not latched");

  irq_cause_a: assert property (
    irq |-> $past(int_enable) && $past(xfer_now))
    else $error("interrupt without enabled completion");

  count_bound_a: assert property (
    (state == st_shift) |-> cnt <= nbits)
    else $error("bit counter overran telegram");

  ack_seen_c: cover property (mcl9 && ack_phase && capture);
  rx_hold_c:  cover property (state == st_hold ##1 state == st_idle);
  partial_c:  cover property (partial);
  stop_c:     cover property (state == st_stop_rel ##1 state == st_off);

endmodule

`default_nettype wire

// ===== bench/serial_peer.sv
/*
  Far-side serial device on the data and clock wires.
  Assumes the wires are synchronous to the system clock.
*/
`default_nettype none

module serial_peer (
  input  wire logic       clk,
  input  wire logic       rise_mode,
  input  wire logic       drive_en,
  input  wire logic       clear,
  input  wire logic [7:0] send_byte,
  input  wire logic       sc,
  input  wire logic       sd,
  output logic      [7:0] got,
  output logic      [2:0] count,
  output logic            sd_drive
);
  timeunit 1ns;
  timeprecision 1ns;

  logic sc_q;
  logic capture;

  // Sample on the edge opposite the launch edge
  assign capture = (sc ^ sc_q) & (sc ^ rise_mode);

  always @(posedge clk) begin
    sc_q <= sc;
    if (clear) begin
      count <= 3'h0;
    end else if (capture) begin
      count <= count + 3'h1;
    end
    if (capture) begin
      got <= {got[6:0], sd};
    end
  end

  // Released line floats high on its pull-up
  assign sd_drive = drive_en ? send_byte[3'h7 - count] : 1'b1;
endmodule

`default_nettype wire

// ===== bench/sync_serial_unit_tb.sv
/*
  Self-checking bench for the synchronous serial unit.
  Assumes the design files and the serial peer are compiled first.
*/
`default_nettype none

module sync_serial_unit_tb;
  import serial_unit_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst, interface_reset_bit, clock_direction_bit, three_wire;
  logic serial_mode_bit1, serial_mode_bit0, data_direction_bit;
  logic combined_mode, int_enable, rx_ack_value, tx_write, rx_read;
  logic t1out_en, pout_en, tog2_en, timer_clk_en, sd_drive;
  logic [1:0] clock_source_sel, div;
  logic [7:0] tx_wdata, receive_buffer, transmit_buffer, send_byte, got;
  logic [2:0] count;
  logic buffer_ready_flag, busy_indicator, tx_ack, irq, timer2_so;
  logic shift_clock_line_i, shift_clock_line_o, shift_clock_line_oe;
  logic serial_data_line_i, serial_data_line_o, serial_data_line_oe;
  int   fails, n_compared, irq_n;

  always #5 clk = ~clk;
  always @(posedge clk) div <= div + 2'h1;
  always @(posedge clk) if (irq === 1'b1) irq_n++;
  assign t1out_en = (div == 2'h0);
  assign pout_en = (div == 2'h1);
  assign tog2_en = (div == 2'h2);
  assign timer_clk_en = (div == 2'h3);
  assign shift_clock_line_i = shift_clock_line_oe ? shift_clock_line_o : 1'b1;
  assign serial_data_line_i = serial_data_line_oe ? serial_data_line_o
                                                  : sd_drive;

  sync_serial_unit sync_serial_unit_inst (.clk, .rst, .interface_reset_bit,
    .clock_direction_bit, .clock_source_sel, .serial_mode_bit1,
    .serial_mode_bit0, .data_direction_bit, .three_wire, .combined_mode,
    .int_enable, .rx_ack_value, .t1out_en, .pout_en, .tog2_en, .timer_clk_en,
    .tx_write, .tx_wdata, .rx_read, .receive_buffer, .transmit_buffer,
    .buffer_ready_flag, .busy_indicator, .tx_ack, .irq, .shift_clock_line_i,
    .shift_clock_line_o, .shift_clock_line_oe, .serial_data_line_i,
    .serial_data_line_o, .serial_data_line_oe, .timer2_so);

  serial_peer serial_peer_inst (.clk, .rise_mode(serial_mode_bit0),
    .drive_en(~data_direction_bit), .clear(interface_reset_bit), .send_byte,
    .sc(shift_clock_line_i), .sd(serial_data_line_i), .got, .count,
    .sd_drive);

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic go(input logic [1:0] mode, input logic dir);
    @(posedge clk);
    interface_reset_bit <= 1'b1;
    {serial_mode_bit1, serial_mode_bit0} <= mode;
    data_direction_bit <= dir;
    cyc(3);
  endtask

  task automatic act;
    irq_n = 0;
    @(posedge clk);
    interface_reset_bit <= 1'b0;
  endtask

  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (irq_n < n && k < 200) begin
      cyc(1);
      k++;
    end
    cyc(2);
  endtask

  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_tx(input logic [1:0] mode, input logic [7:0] b);
    go(mode, 1'b1);
    @(posedge clk);
    tx_write <= 1'b1;
    tx_wdata <= b;
    @(posedge clk);
    tx_write <= 1'b0;
    cyc(3);
    check(buffer_ready_flag, 1);
    check(busy_indicator, 0);
    act;
    cyc(4);
    check(busy_indicator, 1);
    check(serial_data_line_oe, 1);
    wait_irq(1);
    check(got, b);
    check(transmit_buffer, b);
    check(buffer_ready_flag, 0);
    check(busy_indicator, 0);
    check(irq_n, 1);
  endtask

  task automatic t_mcl(input logic [1:0] mode);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    clock_direction_bit <= 1'b0;
    go(mode, 1'b1);
    act;
    repeat (6) begin
      cyc(1);
      seen |= busy_indicator & ~serial_data_line_i & shift_clock_line_oe
              & shift_clock_line_o;
    end
    check(seen, 1);
    go(mode, 1'b1);
    cyc(8);
    check(serial_data_line_i, 1);
    check(busy_indicator, 0);
    clock_direction_bit <= 1'b1;
  endtask

  task automatic t_rx;
    int k;
    logic [7:0] m;
    go(MODE_NRZ_FALL, 1'b0);
    send_byte = 8'hc6;
    act;
    wait_irq(1);
    check(receive_buffer, 8'hc6);
    check(buffer_ready_flag, 0);
    cyc(60);
    check(receive_buffer, 8'hc6);
    check(busy_indicator, 0);
    check(irq_n, 1);
    @(posedge clk);
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
    wait_irq(2);
    check(irq_n, 2);
    go(MODE_NRZ_FALL, 1'b0);
    act;
    k = 0;
    while (count != 3'h3 && k < 100) begin
      cyc(1);
      k++;
    end
    @(posedge clk);
    interface_reset_bit <= 1'b1;
    cyc(4);
    // Four bits are in when the cut lands with the system clock source
    m = 8'h0f;
    check(receive_buffer & m, 8'h0c);
    check(irq_n, 0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------
  initial begin
    {clk, div, tx_wdata, send_byte, irq_n, fails, n_compared} = '0;
    {rst, interface_reset_bit, clock_direction_bit, int_enable} = 4'hf;
    {serial_mode_bit1, serial_mode_bit0, data_direction_bit} = 3'h7;
    {three_wire, combined_mode, rx_ack_value, tx_write, rx_read} = '0;
    clock_source_sel = CLKSEL_SYS;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    check(receive_buffer, RST_BUF);
    check(buffer_ready_flag, RST_RDY);
    check(busy_indicator, 0);
    check(irq, 0);
    t_tx(MODE_NRZ_FALL, 8'ha5);
    t_tx(MODE_NRZ_RISE, 8'h3c);
    @(posedge clk);
    combined_mode <= 1'b1;
    t_tx(MODE_NRZ_RISE, 8'h96);
    @(posedge clk);
    combined_mode <= 1'b0;
    t_mcl(MODE_MCL9);
    t_mcl(MODE_MCL8);
    t_rx;
    complete_run;
  end

  initial begin
    #200000;
    fails++;
    complete_run;
  end
endmodule

`default_nettype wire
